// ===== design/dctg_pkg.sv
// Package: command codes and DRAM command timing in memory clock cycles
package dctg_pkg;

  // ==========================================================
  // Commands presented by the user side
  typedef enum logic [2:0] {
    DCTG_NOP, DCTG_MRS, DCTG_ACT, DCTG_RD, DCTG_WR, DCTG_PRE, DCTG_REF,
    DCTG_SRX
  } dctg_cmd_t;

  // ==========================================================
  // Clock period columns, tenths of ns
  localparam int TCK_FAST_TENTHS = 60;
  localparam int TCK_SLOW_TENTHS = 75;

  // ==========================================================
  // Cycle counts, fast column then slow column
  localparam int MODE_SET_GAP_CYC          = 2;
  localparam int ACT_TO_PRE_MIN_FAST       = 7;
  localparam int ACT_TO_PRE_MIN_SLOW       = 6;
  localparam int ACT_TO_PRE_MAX_FAST       = 20000;
  localparam int ACT_TO_PRE_MAX_SLOW       = 16000;
  localparam int ACT_TO_ACT_SAME_FAST      = 10;
  localparam int ACT_TO_ACT_SAME_SLOW      = 9;
  localparam int REFRESH_CYCLE_GAP_FAST    = 12;
  localparam int REFRESH_CYCLE_GAP_SLOW    = 10;
  localparam int ACT_TO_RW_DELAY_CYC       = 3;
  localparam int ACT_TO_RDAP_CYC           = 3;
  localparam int PRE_PERIOD_CYC            = 3;
  localparam int ACT_TO_ACT_OTHER_BANK_CYC = 2;
  localparam int WRITE_TO_READ_GAP_CYC     = 1;
  localparam int SELFREF_EXIT_NONREAD_FAST = 13;
  localparam int SELFREF_EXIT_NONREAD_SLOW = 10;
  localparam int SELFREF_EXIT_READ_GAP_CYC = 200;
  localparam int MAX_POSTED_REFRESH        = 8;

  // Write recovery and precharge times in tenths of ns
  localparam int WRITE_RECOVERY_TENTHS     = 150;
  localparam int PRE_PERIOD_FAST_TENTHS    = 180;
  localparam int PRE_PERIOD_SLOW_TENTHS    = 200;

  // Average refresh interval in ns
  localparam int AVG_REFRESH_INTERVAL_NS   = 7800;

  // Ceiling division: each term rounded up before summing
  function automatic int dctg_ceil_div(input int num, input int den);
    return (num + den - 1) / den;
  endfunction

endpackage

// ===== design/dctg_down_counter.sv
// Loadable down counter used for every command spacing timer
module dctg_down_counter
  import dctg_pkg::*;
#(
  parameter int W = 15
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         step,
  output logic              done,
  output logic [W-1:0]      count
);

  logic [W-1:0] cnt_q;

  // ==========================================================
  // Count
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (step && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign done  = (cnt_q == '0);
  assign count = cnt_q;

endmodule

// ===== design/dctg_guard.sv
// Controller-side command timing guard for a four-bank DDR DRAM
// ==========================================================
// Summary of operation
// - Hold two cycles after mode register set before any command.
// - Activate-to-precharge at least 7/6 cycles, at most 20000/16000.
// - Same-bank activate or refresh spacing at least 10/9 cycles.
// - After refresh wait 12/10 cycles before activate or refresh.
// - Read/write 3 cycles after activate; activate 3 after precharge.
// - Read with auto-precharge at least 7/6 cycles after activate (activate-to-precharge minimum).
// - Activates to different banks at least 2 cycles apart.
// - Write auto-precharge recovery 6/5 cycles; plain write recovery 3/2.
// - Auto-precharge recovery rounds each time quotient up before summing.
// - At least one cycle from write to a following read.
// - After self-refresh exit, non-read commands wait 13/10 cycles.
// - No more than eight refreshes may be owed at once.
// - Strobe postamble maxima are not errors; never flagged.
// - Strobe driven low from high impedance as write preamble.
// - Preamble lasts at least a quarter clock before first edge.
// - After self-refresh exit, reads wait 200 cycles.
// - Refreshes average no more than 7.8 microseconds apart.
module dctg_guard
  import dctg_pkg::*;
#(
  parameter bit FAST_CLK     = 1'b1,
  parameter int BANKS        = 4,
  parameter int CORE_CLK_MHZ = 50,
  parameter int RAS_MAX_FAST = ACT_TO_PRE_MAX_FAST,
  parameter int RAS_MAX_SLOW = ACT_TO_PRE_MAX_SLOW,
  parameter int REFI_CORE    = AVG_REFRESH_INTERVAL_NS * CORE_CLK_MHZ / 1000
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              mem_clk,
  input  wire logic              cmd_valid,
  input  wire dctg_cmd_t         cmd,
  input  wire logic [1:0]        cmd_bank,
  input  wire logic              cmd_autopre,
  output logic                   cmd_ready,
  output dctg_cmd_t              mem_cmd,
  output logic [1:0]             mem_bank,
  output logic                   mem_autopre,
  output logic                   dqs_out,
  output logic                   dqs_oe_n,
  output logic                   ras_overdue,
  output logic                   refresh_due,
  output logic [3:0]             refresh_owed
);

  // ==========================================================
  // Column selection
  localparam int RAS_MIN = FAST_CLK ? ACT_TO_PRE_MIN_FAST : ACT_TO_PRE_MIN_SLOW;
  localparam int RAS_MAX = FAST_CLK ? RAS_MAX_FAST : RAS_MAX_SLOW;
  localparam int RC  = FAST_CLK ? ACT_TO_ACT_SAME_FAST : ACT_TO_ACT_SAME_SLOW;
  localparam int RFC = FAST_CLK ? REFRESH_CYCLE_GAP_FAST : REFRESH_CYCLE_GAP_SLOW;
  localparam int XSNR = FAST_CLK ? SELFREF_EXIT_NONREAD_FAST
                                 : SELFREF_EXIT_NONREAD_SLOW;
  localparam int TCK  = FAST_CLK ? TCK_FAST_TENTHS : TCK_SLOW_TENTHS;
  localparam int RP_T = FAST_CLK ? PRE_PERIOD_FAST_TENTHS : PRE_PERIOD_SLOW_TENTHS;
  localparam int WR_CYC = dctg_ceil_div(WRITE_RECOVERY_TENTHS, TCK);
  localparam int DAL_CYC = WR_CYC + dctg_ceil_div(RP_T, TCK);
  localparam int CW = 15;

  // ==========================================================
  // Memory clock edge detect
  logic mclk_s1_q, mclk_s2_q, mclk_s3_q, mclk_rise;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mclk_s1_q <= 1'b0;
      mclk_s2_q <= 1'b0;
      mclk_s3_q <= 1'b0;
    end else begin
      mclk_s1_q <= mem_clk;
      mclk_s2_q <= mclk_s1_q;
      mclk_s3_q <= mclk_s2_q;
    end
  end
  assign mclk_rise = mclk_s2_q & ~mclk_s3_q;

  // ==========================================================
  // Counters: per bank and global
  logic [BANKS-1:0]          act_ld, pre_ld, wr_ld, rw_ld, ras_ld;
  logic [BANKS-1:0]          rc_ok, rcd_ok, rp_ok, wr_ok, ras_ok;
  logic [BANKS-1:0]          open_q, wr_ap_q;
  logic [BANKS-1:0][CW-1:0]  rp_val, ras_cnt;
  logic                      issue;
  logic                      glob_ld, rrd_ok, mrd_ok, rfc_ok, xsnr_ok, xsrd_ok;
  logic                      wtr_ok;

  assign issue = cmd_valid & cmd_ready & mclk_rise;

  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    logic hit;
    assign hit = issue && (cmd_bank == 2'(b));
    assign act_ld[b] = hit && (cmd == DCTG_ACT);
    assign pre_ld[b] = (hit && (cmd == DCTG_PRE)) ||
                       (hit && (cmd == DCTG_RD) && cmd_autopre);
    assign wr_ld[b]  = hit && (cmd == DCTG_WR);
    // After write with auto-precharge, recovery plus precharge gates activate
    assign rp_val[b] = wr_ap_q[b] ? CW'(DAL_CYC) : CW'(PRE_PERIOD_CYC);
    dctg_down_counter #(.W(CW)) u_rc (
      .core_clk (core_clk), .srst (srst),
      .load     (act_ld[b] | (issue && cmd == DCTG_REF)),
      .load_val ((issue && cmd == DCTG_REF) ? CW'(RFC) : CW'(RC)),
      .step     (mclk_rise),
      .done     (rc_ok[b]), .count ());
    dctg_down_counter #(.W(CW)) u_rcd (
      .core_clk (core_clk), .srst (srst), .load (act_ld[b]),
      .load_val (CW'(ACT_TO_RW_DELAY_CYC)),
      .step     (mclk_rise),
      .done     (rcd_ok[b]), .count ());
    dctg_down_counter #(.W(CW)) u_rp (
      .core_clk (core_clk), .srst (srst),
      .load     (pre_ld[b] | (wr_ld[b] & cmd_autopre)),
      .load_val ((wr_ld[b] & cmd_autopre) ? CW'(DAL_CYC) : rp_val[b]),
      .step     (mclk_rise),
      .done     (rp_ok[b]), .count ());
    dctg_down_counter #(.W(CW)) u_wr (
      .core_clk (core_clk), .srst (srst), .load (wr_ld[b]),
      .load_val (CW'(WR_CYC)),
      .step     (mclk_rise),
      .done     (wr_ok[b]), .count ());
    dctg_down_counter #(.W(CW)) u_ras (
      .core_clk (core_clk), .srst (srst), .load (act_ld[b]),
      .load_val (CW'(RAS_MIN)),
      .step     (mclk_rise),
      .done     (ras_ok[b]), .count ());
    dctg_down_counter #(.W(CW)) u_open (
      .core_clk (core_clk), .srst (srst), .load (act_ld[b]),
      .load_val (CW'(RAS_MAX)),
      .step     (mclk_rise),
      .done     (), .count (ras_cnt[b]));

    always_ff @(posedge core_clk) begin
      if (srst) begin
        open_q[b]  <= 1'b0;
        wr_ap_q[b] <= 1'b0;
      end else begin
        if (act_ld[b]) begin
          open_q[b] <= 1'b1;
        end else if (pre_ld[b] || (wr_ld[b] && cmd_autopre)) begin
          open_q[b] <= 1'b0;
        end
        if (wr_ld[b]) begin
          wr_ap_q[b] <= cmd_autopre;
        end
      end
    end
  end

  assign glob_ld = issue && (cmd == DCTG_ACT);
  dctg_down_counter #(.W(CW)) u_rrd (
    .core_clk (core_clk), .srst (srst), .load (glob_ld),
    .load_val (CW'(ACT_TO_ACT_OTHER_BANK_CYC)),
    .step     (mclk_rise),
    .done     (rrd_ok), .count ());
  dctg_down_counter #(.W(CW)) u_mrd (
    .core_clk (core_clk), .srst (srst), .load (issue && cmd == DCTG_MRS),
    .load_val (CW'(MODE_SET_GAP_CYC)),
    .step     (mclk_rise),
    .done     (mrd_ok), .count ());
  dctg_down_counter #(.W(CW)) u_rfc (
    .core_clk (core_clk), .srst (srst), .load (issue && cmd == DCTG_REF),
    .load_val (CW'(RFC)),
    .step     (mclk_rise),
    .done     (rfc_ok), .count ());
  dctg_down_counter #(.W(CW)) u_wtr (
    .core_clk (core_clk), .srst (srst), .load (issue && cmd == DCTG_WR),
    .load_val (CW'(WRITE_TO_READ_GAP_CYC + 1)),
    .step     (mclk_rise),
    .done     (wtr_ok), .count ());
  dctg_down_counter #(.W(CW)) u_xsnr (
    .core_clk (core_clk), .srst (srst), .load (issue && cmd == DCTG_SRX),
    .load_val (CW'(XSNR)),
    .step     (mclk_rise),
    .done     (xsnr_ok), .count ());
  dctg_down_counter #(.W(CW)) u_xsrd (
    .core_clk (core_clk), .srst (srst), .load (issue && cmd == DCTG_SRX),
    .load_val (CW'(SELFREF_EXIT_READ_GAP_CYC)),
    .step     (mclk_rise),
    .done     (xsrd_ok), .count ());

  // Counters step once per memory clock rise, so every gap is counted
  // in memory clocks; the load edge adds one clock of margin.

  // ==========================================================
  // Command acceptance
  logic bank_ok;
  always_comb begin
    bank_ok = 1'b1;
    unique case (cmd)
      DCTG_NOP: bank_ok = 1'b1;
      DCTG_MRS: bank_ok = ~|open_q;
      DCTG_ACT: bank_ok = rc_ok[cmd_bank] & rp_ok[cmd_bank] & rrd_ok &
                          rfc_ok & ~open_q[cmd_bank];
      DCTG_RD:  bank_ok = rcd_ok[cmd_bank] & open_q[cmd_bank] & wtr_ok &
                          (~cmd_autopre | ras_ok[cmd_bank]) & xsrd_ok;
      DCTG_WR:  bank_ok = rcd_ok[cmd_bank] & open_q[cmd_bank];
      DCTG_PRE: bank_ok = ras_ok[cmd_bank] & wr_ok[cmd_bank];
      DCTG_REF: bank_ok = rfc_ok & ~|open_q & (&rc_ok);
      DCTG_SRX: bank_ok = 1'b1;
    endcase
  end
  assign cmd_ready = mrd_ok & bank_ok &
                     ((cmd == DCTG_RD) | (cmd == DCTG_NOP) | xsnr_ok);

  // ==========================================================
  // Command outputs, held one memory clock
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_cmd     <= DCTG_NOP;
      mem_bank    <= 2'h0;
      mem_autopre <= 1'b0;
    end else if (mclk_rise) begin
      mem_cmd     <= issue ? cmd : DCTG_NOP;
      mem_bank    <= cmd_bank;
      mem_autopre <= cmd_autopre;
    end
  end

  // ==========================================================
  // Write strobe preamble: drive low a full clock ahead of data
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dqs_oe_n <= 1'b1;
      dqs_out  <= 1'b0;
    end else if (mclk_rise) begin
      dqs_oe_n <= ~(issue && cmd == DCTG_WR);
      dqs_out  <= 1'b0;
    end
  end

  // ==========================================================
  // Open-row overstay and refresh debt; postamble maxima unchecked
  logic [BANKS-1:0] over;
  for (genvar b = 0; b < BANKS; b++) begin : g_over
    assign over[b] = open_q[b] && (ras_cnt[b] == '0);
  end
  assign ras_overdue = |over;

  logic [CW-1:0] refi_q;
  logic [3:0]    owed_q;
  logic          refi_tick, ref_done;
  assign refi_tick = (refi_q == '0);
  assign ref_done  = issue && (cmd == DCTG_REF);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      refi_q <= '0;
      owed_q <= 4'h0;
    end else begin
      refi_q <= refi_tick ? CW'(REFI_CORE - 1) : refi_q - CW'(1);
      if (refi_tick && !ref_done && owed_q != 4'(MAX_POSTED_REFRESH)) begin
        owed_q <= owed_q + 4'h1;
      end else if (!refi_tick && ref_done && owed_q != 4'h0) begin
        owed_q <= owed_q - 4'h1;
      end
    end
  end
  assign refresh_owed = owed_q;
  assign refresh_due  = (owed_q != 4'h0);

endmodule

// ===== verification/dctg_guard_properties.sv
// Checker: command spacing of the guard, counted in memory clocks
module dctg_guard_properties
  import dctg_pkg::*;
#(
  parameter bit FAST_CLK = 1'b1
) (
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       mem_clk,
  input wire dctg_cmd_t  mem_cmd,
  input wire logic [1:0] mem_bank,
  input wire logic       mem_autopre,
  input wire logic       dqs_out,
  input wire logic       dqs_oe_n,
  input wire logic       refresh_due,
  input wire logic [3:0] refresh_owed
);
  localparam int TCK  = FAST_CLK ? TCK_FAST_TENTHS : TCK_SLOW_TENTHS;
  localparam int RPT  = FAST_CLK ? 180 : 200;
  localparam int DAL  = (150 + TCK - 1) / TCK + (RPT + TCK - 1) / TCK;
  localparam int RAS  = FAST_CLK ? 7 : 6;
  localparam int RC   = FAST_CLK ? 10 : 9;
  localparam int RFC  = FAST_CLK ? 12 : 10;
  localparam int XSNR = FAST_CLK ? 13 : 10;
  // ==========================================================
  // Clocks since ACT, PRE, WR-autopre per bank; any ACT, REF, MRS, SRX
  logic [1:0] sy_q;
  dctg_cmd_t  prev_q;
  logic [1:0] pbank_q;
  logic [7:0] cnt_q [16];
  logic       tick;
  logic       evt;
  assign tick = sy_q[0] & ~sy_q[1];
  assign evt = mem_cmd != DCTG_NOP && (mem_cmd != prev_q || mem_bank != pbank_q);
  function automatic logic hit(input int i);
    case (i)
      12: return mem_cmd == DCTG_ACT;
      13: return mem_cmd == DCTG_REF;
      14: return mem_cmd == DCTG_MRS;
      15: return mem_cmd == DCTG_SRX;
      default: return mem_bank == 2'(i % 4) && (i < 4 ? mem_cmd == DCTG_ACT :
        i < 8 ? mem_cmd == DCTG_PRE : mem_cmd == DCTG_WR && mem_autopre);
    endcase
  endfunction
  always_ff @(posedge core_clk) begin
    sy_q <= {sy_q[0], mem_clk};
    prev_q <= srst ? DCTG_NOP : mem_cmd;
    pbank_q <= mem_bank;
    for (int i = 0; i < 16; i++) begin
      if (srst) cnt_q[i] <= 8'hFF;
      else if (evt && hit(i)) cnt_q[i] <= 8'h00;
      else if (tick && cnt_q[i] != 8'hFF) cnt_q[i] <= cnt_q[i] + 8'h01;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_MRS_GAP: assert property (evt |-> cnt_q[14] >= 2)
    else $error("command too soon after mode set");
  AST_ACT_PRE_MIN: assert property (evt && mem_cmd == DCTG_PRE |->
    cnt_q[mem_bank] >= RAS) else $error("precharge too soon after activate");
  AST_SAME_BANK: assert property (evt && mem_cmd == DCTG_ACT |->
    cnt_q[mem_bank] >= RC) else $error("same bank activate too soon");
  AST_REF_GAP: assert property (evt && mem_cmd inside {DCTG_ACT, DCTG_REF}
    |-> cnt_q[13] >= RFC) else $error("command too soon after refresh");
  AST_ACT_TO_RW: assert property (evt && mem_cmd inside {DCTG_RD, DCTG_WR}
    |-> cnt_q[mem_bank] >= 3) else $error("access too soon after activate");
  AST_PRE_TO_ACT: assert property (evt && mem_cmd == DCTG_ACT |->
    cnt_q[4 + mem_bank] >= 3) else $error("activate too soon after precharge");
  AST_OTHER_BANK: assert property (evt && mem_cmd == DCTG_ACT |->
    cnt_q[12] >= 2) else $error("activates too close");
  AST_WRITE_AUTOPRE: assert property (evt && mem_cmd == DCTG_ACT |->
    cnt_q[8 + mem_bank] >= DAL) else $error("activate inside write recovery");
  AST_SELFREF_OTHER: assert property (evt && mem_cmd != DCTG_RD |->
    cnt_q[15] >= XSNR) else $error("command too soon after self refresh");
  AST_SELFREF_READ: assert property (evt && mem_cmd == DCTG_RD |->
    cnt_q[15] >= 200) else $error("read too soon after self refresh");
  AST_OWED_MAX: assert property (refresh_owed <= 4'h8 &&
    refresh_due == (refresh_owed != 4'h0)) else $error("refresh owed wrong");
  AST_PREAMBLE: assert property ($fell(dqs_oe_n) |->
    (!dqs_out && !dqs_oe_n) [*2]) else $error("strobe preamble wrong");
endmodule

bind dctg_guard dctg_guard_properties #(.FAST_CLK(FAST_CLK)) u_props (
  .core_clk(core_clk), .srst(srst), .mem_clk(mem_clk), .mem_cmd(mem_cmd),
  .mem_bank(mem_bank), .mem_autopre(mem_autopre), .dqs_out(dqs_out),
  .dqs_oe_n(dqs_oe_n), .refresh_due(refresh_due),
  .refresh_owed(refresh_owed));

// ===== verification/dctg_dram_model.sv
// Device model: bank state of a four-bank DRAM fed by the guard
module dctg_dram_model
  import dctg_pkg::*;
(
  input  wire logic       mem_clk,
  input  wire dctg_cmd_t  mem_cmd,
  input  wire logic [1:0] mem_bank,
  input  wire logic       mem_autopre,
  output int              bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] open_q = '0;
  initial bad = 0;
  // ==========================================================
  // Commands taken at each clock rise; late postamble never counted
  always @(posedge mem_clk) begin
    case (mem_cmd)
      DCTG_ACT: begin
        if (open_q[mem_bank]) bad++;
        open_q[mem_bank] = 1'b1;
      end
      DCTG_RD, DCTG_WR: begin
        if (!open_q[mem_bank]) bad++;
        if (mem_autopre) open_q[mem_bank] = 1'b0;
      end
      DCTG_PRE: open_q[mem_bank] = 1'b0;
      DCTG_REF, DCTG_MRS: if (open_q != 4'h0) bad++;
      default: ;
    endcase
  end
endmodule

// ===== verification/dctg_guard_test.sv
// Testbench: directed and random command traffic through the guard
module dctg_guard_test import dctg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, srst = 1, mem_clk = 0, cmd_valid = 0, cmd_autopre = 0;
  dctg_cmd_t  cmd = DCTG_NOP;
  dctg_cmd_t  mem_cmd;
  logic [1:0] cmd_bank = '0;
  logic [1:0] mem_bank;
  logic [3:0] refresh_owed;
  logic [3:0] open_q = '0;
  logic cmd_ready, mem_autopre, dqs_out, dqs_oe_n, ras_overdue, refresh_due;
  int fails = 0, n_compared = 0, cyc = 0, bad, i;
  always #10 core_clk = ~core_clk;
  initial begin
    #37;
    forever #80 mem_clk = ~mem_clk;
  end
  dctg_guard #(.FAST_CLK(1'b1), .RAS_MAX_FAST(50), .REFI_CORE(400)) u_dctg_guard (
    .core_clk(core_clk), .srst(srst), .mem_clk(mem_clk),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_bank(cmd_bank),
    .cmd_autopre(cmd_autopre), .cmd_ready(cmd_ready), .mem_cmd(mem_cmd),
    .mem_bank(mem_bank), .mem_autopre(mem_autopre), .dqs_out(dqs_out),
    .dqs_oe_n(dqs_oe_n), .ras_overdue(ras_overdue),
    .refresh_due(refresh_due), .refresh_owed(refresh_owed));
  dctg_dram_model u_dctg_dram_model (.mem_clk(mem_clk), .mem_cmd(mem_cmd),
    .mem_bank(mem_bank), .mem_autopre(mem_autopre), .bad(bad));
  // ==========================================================
  // Checking and driving
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // 1 taken, 0 refused, 2 not predicted
  function automatic int expect_take(dctg_cmd_t c, logic [1:0] b);
    case (c)
      DCTG_ACT: return open_q[b] ? 0 : 1;
      DCTG_RD, DCTG_WR: return open_q[b] ? 1 : 0;
      DCTG_PRE: return open_q[b] ? 1 : 2;
      DCTG_REF: return open_q != 4'h0 ? 0 : 1;
      default: return 2;
    endcase
  endfunction
  task automatic send(input dctg_cmd_t c, input logic [1:0] b, input logic ap);
    int e, k;
    logic took;
    e = expect_take(c, b);
    took = 1'b0;
    cmd <= c;
    cmd_bank <= b;
    cmd_autopre <= ap;
    cmd_valid <= 1'b1;
    for (k = 0; k < (e == 0 ? 40 : 2000) && !took; k++) begin
      @(posedge core_clk);
      took = mem_cmd === c && mem_bank === b;
    end
    cmd_valid <= 1'b0;
    if (e != 2) check(4'(took), 4'(e));
    if (took && c == DCTG_ACT) open_q[b] = 1'b1;
    if (took && (c == DCTG_PRE || (ap && c inside {DCTG_RD, DCTG_WR})))
      open_q[b] = 1'b0;
    if (took && c == DCTG_WR) begin
      for (k = 0; k < 20 && dqs_oe_n !== 1'b0; k++) @(posedge core_clk);
      check({dqs_oe_n, dqs_out}, 4'h0);
    end
    repeat (10) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 95000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    i = $urandom(32'h7529DA64);
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check(refresh_owed, 4'h0);
    send(DCTG_MRS, 2'h0, 1'b0);
    send(DCTG_RD, 2'h1, 1'b0);
    send(DCTG_ACT, 2'h0, 1'b0);
    send(DCTG_ACT, 2'h1, 1'b0);
    send(DCTG_ACT, 2'h0, 1'b0);
    send(DCTG_RD, 2'h0, 1'b1);
    send(DCTG_WR, 2'h1, 1'b0);
    send(DCTG_RD, 2'h1, 1'b0);
    repeat (450) @(posedge core_clk);
    check(4'(ras_overdue), 4'h1);
    send(DCTG_WR, 2'h1, 1'b1);
    send(DCTG_ACT, 2'h1, 1'b0);
    send(DCTG_PRE, 2'h1, 1'b0);
    send(DCTG_REF, 2'h0, 1'b0);
    send(DCTG_REF, 2'h0, 1'b0);
    send(DCTG_SRX, 2'h0, 1'b0);
    send(DCTG_ACT, 2'h2, 1'b0);
    send(DCTG_RD, 2'h2, 1'b0);
    send(DCTG_PRE, 2'h2, 1'b0);
    check(4'(ras_overdue), 4'h0);
    repeat (3300) @(posedge core_clk);
    check(8'({refresh_due, refresh_owed}), 8'h18);
    for (i = 0; i < 60; i++)
      send(dctg_cmd_t'(3'($urandom_range(2, 6))), 2'($urandom_range(0, 3)),
           1'($urandom_range(0, 1)));
    check(4'(bad != 0), 4'h0);
    give_verdict();
  end
endmodule
